// ### rtl/pamr_mdio_slave.sv
// Clause 22 management frame slave: preamble, start, opcode, addresses,
// turnaround, then 16 data bits. Decodes on the synchronised MDC rising edge; read data shifts on the falling edge.
module pamr_mdio_slave (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Synchronised pins
  input wire logic i_mdc_rise,
  input wire logic i_mdc_fall,
  input wire logic i_mdio,
  input wire logic [4:0] i_phy_addr,
  // Register access
  output logic o_wr_stb,
  output logic o_rd_stb,
  output logic [4:0] o_reg_addr,
  output logic [15:0] o_wr_data,
  input wire logic [15:0] i_rd_data,
  // Data pin drive
  output logic o_mdio_out,
  output logic o_mdio_oe
);

  typedef enum logic [2:0] {
    PAMR_IDLE = 3'b000,
    PAMR_HEADER = 3'b001,
    PAMR_TURN = 3'b011,
    PAMR_DATA = 3'b010
  } pamr_mf_state_t;

  pamr_mf_state_t state_q;
  logic [5:0] count_q;
  logic [13:0] hdr_q;
  logic [15:0] shift_q;
  logic is_read_q;
  logic mine_q;
  logic drive_q;

  wire logic hdr_ok = (hdr_q[13:12] == pamr_pkg::MF_START) && (hdr_q[9:5] == i_phy_addr);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= PAMR_IDLE;
      count_q <= 6'h00;
      hdr_q <= 14'h0000;
      is_read_q <= 1'b0;
      mine_q <= 1'b0;
      o_wr_stb <= 1'b0;
      o_rd_stb <= 1'b0;
      o_reg_addr <= 5'h00;
      o_wr_data <= 16'h0000;
    end else begin
      o_wr_stb <= 1'b0;
      o_rd_stb <= 1'b0;
      if (i_mdc_rise) begin
        unique case (state_q)
          PAMR_IDLE: begin
            count_q <= i_mdio ? ((count_q == 6'h3F) ? count_q : count_q + 6'h01) : 6'h00;
            if (!i_mdio && count_q >= 6'(pamr_pkg::MF_PREAMBLE_BITS)) begin
              state_q <= PAMR_HEADER;
              hdr_q <= 14'h0000;
              count_q <= 6'h01;
            end
          end
          PAMR_HEADER: begin
            hdr_q <= {hdr_q[12:0], i_mdio};
            count_q <= count_q + 6'h01;
            if (count_q == 6'(pamr_pkg::MF_HEADER_BITS - 1)) begin
              state_q <= PAMR_TURN;
              count_q <= 6'h00;
            end
          end
          PAMR_TURN: begin
            is_read_q <= hdr_q[11:10] == pamr_pkg::MF_OP_READ;
            mine_q <= hdr_ok && (hdr_q[11:10] == pamr_pkg::MF_OP_READ ||
                                 hdr_q[11:10] == pamr_pkg::MF_OP_WRITE);
            count_q <= count_q + 6'h01;
            if (count_q == 6'h01) begin
              state_q <= PAMR_DATA;
              count_q <= 6'h00;
              o_rd_stb <= hdr_ok && hdr_q[11:10] == pamr_pkg::MF_OP_READ;
            end
          end
          PAMR_DATA: begin
            o_wr_data <= {o_wr_data[14:0], i_mdio};
            count_q <= count_q + 6'h01;
            if (count_q == 6'h0F) begin
              state_q <= PAMR_IDLE;
              count_q <= 6'h00;
              o_wr_stb <= mine_q && !is_read_q;
            end
          end
        endcase
      end
      if (state_q == PAMR_HEADER && i_mdc_rise && count_q == 6'(pamr_pkg::MF_HEADER_BITS - 1)) begin
        o_reg_addr <= {hdr_q[3:0], i_mdio};
      end
    end
  end

  // Read data is loaded after the read strobe and shifted on MDC falling edges.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      shift_q <= 16'h0000;
      drive_q <= 1'b0;
    end else begin
      if (o_rd_stb) begin
        shift_q <= i_rd_data;
        drive_q <= 1'b1;
      end else if (state_q == PAMR_DATA && i_mdc_fall && drive_q && count_q != 6'h00) begin
        shift_q <= {shift_q[14:0], 1'b0};
      end
      if (state_q != PAMR_DATA && state_q != PAMR_TURN) begin
        drive_q <= 1'b0;
      end
    end
  end

  assign o_mdio_out = shift_q[15];
  assign o_mdio_oe = drive_q && state_q == PAMR_DATA;

endmodule : pamr_mdio_slave

// ### rtl/pamr_pkg.sv
package pamr_pkg;

  // Register addresses on the serial management port.
  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam logic [4:0] REG_ADVERTISED = 5'h04;
  localparam logic [4:0] REG_PARTNER = 5'h05;
  localparam logic [4:0] REG_EXPANSION = 5'h06;
  localparam logic [4:0] REG_EXT_STATUS = 5'h0F;

  // Arbitrary port address of this block on the management link.
  localparam logic [4:0] PHY_ADDR_DEFAULT = 5'h00;

  // Control register fields.
  localparam int CTL_RESET_BIT = 15;
  localparam int CTL_LOOPBACK_BIT = 14;
  localparam int CTL_SPEED_LO_BIT = 13;
  localparam int CTL_AN_ENABLE_BIT = 12;
  localparam int CTL_POWER_DOWN_BIT = 11;
  localparam int CTL_ISOLATE_BIT = 10;
  localparam int CTL_AN_RESTART_BIT = 9;
  localparam int CTL_DUPLEX_BIT = 8;
  localparam int CTL_SPEED_HI_BIT = 6;
  localparam int CTL_UNIDIR_BIT = 5;
  localparam logic [15:0] CTL_RESET_VALUE = 16'h1140;
  localparam logic [15:0] CTL_WRITE_MASK = 16'hFF60;

  // Status register constants and live bit positions.
  localparam logic [15:0] STS_FIXED_ONES = 16'h0108;
  localparam int STS_UNIDIR_BIT = 7;
  localparam int STS_AN_DONE_BIT = 5;
  localparam int STS_LINK_BIT = 2;

  // Advertised word masks and fixed values.
  localparam logic [15:0] ADV_GBE_RESET = 16'h0020;
  localparam logic [15:0] ADV_PHY_MASK = 16'hDC00;
  localparam logic [15:0] ADV_SGMII_ONE = 16'h0001;
  localparam logic [15:0] ADV_MAC_VALUE = 16'h4001;
  localparam logic [15:0] LP_SGMII_MASK = 16'hDC00;
  localparam int ADV_SPEED_LSB = 10;

  localparam int EXP_PAGE_BIT = 1;
  localparam logic [15:0] EXT_STATUS_VALUE = 16'h8000;

  // Speed selection codes.
  localparam logic [1:0] SPEED_1G = 2'h2;
  localparam logic [1:0] SPEED_100M = 2'h1;
  localparam logic [1:0] SPEED_10M = 2'h0;

  // Management frame constants.
  localparam logic [1:0] MF_START = 2'h1;
  localparam logic [1:0] MF_OP_WRITE = 2'h1;
  localparam logic [1:0] MF_OP_READ = 2'h2;
  localparam int MF_PREAMBLE_BITS = 32;
  localparam int MF_HEADER_BITS = 14;

  typedef struct packed {
    logic gbe_mode;
    logic sgmii_phy_side;
    logic link_up;
    logic an_complete;
    logic unidir_able;
    logic page_received;
    logic [15:0] partner_word;
  } pamr_pcs_status_t;

  typedef struct packed {
    logic soft_reset;
    logic loopback;
    logic an_enable;
    logic an_restart;
    logic power_down;
    logic isolate;
    logic unidirectional;
    logic [1:0] operational_rate;
    logic [15:0] advertised_word;
  } pamr_pcs_control_t;

endpackage : pamr_pkg

// ### rtl/pamr_regs.sv
module pamr_regs (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Management pins
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_mdio,
  output logic o_mdio_oe,
  input wire logic [4:0] i_phy_addr,
  // PCS side
  input wire pamr_pkg::pamr_pcs_status_t i_pcs,
  output pamr_pkg::pamr_pcs_control_t o_ctl
);

  logic [2:0] mdc_sync_q;
  logic [1:0] mdio_sync_q;
  logic wr_stb;
  logic rd_stb;
  logic [4:0] reg_addr;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic [15:0] ctl_q;
  logic [15:0] adv_q;
  logic link_latch_q;
  logic page_latch_q;
  logic [15:0] adv_view;
  logic [15:0] partner_view;
  logic [1:0] speed_sel;

  // Two-stage synchronisers; the edge detector reads only stages two and three.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mdc_sync_q <= 3'h0;
      mdio_sync_q <= 2'h0;
    end else begin
      mdc_sync_q <= {mdc_sync_q[1:0], i_mdc};
      mdio_sync_q <= {mdio_sync_q[0], i_mdio};
    end
  end

  pamr_mdio_slave u_mdio (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_mdc_rise(mdc_sync_q[1] && !mdc_sync_q[2]),
    .i_mdc_fall(!mdc_sync_q[1] && mdc_sync_q[2]),
    .i_mdio(mdio_sync_q[1]),
    .i_phy_addr(i_phy_addr),
    .o_wr_stb(wr_stb),
    .o_rd_stb(rd_stb),
    .o_reg_addr(reg_addr),
    .o_wr_data(wr_data),
    .i_rd_data(rd_data),
    .o_mdio_out(o_mdio),
    .o_mdio_oe(o_mdio_oe)
  );

  // Control register; reset and restart bits clear themselves after one cycle.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl_q <= pamr_pkg::CTL_RESET_VALUE;
    end else if (wr_stb && reg_addr == pamr_pkg::REG_CONTROL) begin
      ctl_q <= wr_data & pamr_pkg::CTL_WRITE_MASK;
    end else begin
      ctl_q[pamr_pkg::CTL_RESET_BIT] <= 1'b0;
      ctl_q[pamr_pkg::CTL_AN_RESTART_BIT] <= 1'b0;
    end
  end

  // Advertised word store; what is visible depends on the mode.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      adv_q <= pamr_pkg::ADV_GBE_RESET;
    end else if (ctl_q[pamr_pkg::CTL_RESET_BIT]) begin
      adv_q <= pamr_pkg::ADV_GBE_RESET;
    end else if (wr_stb && reg_addr == pamr_pkg::REG_ADVERTISED) begin
      adv_q <= wr_data;
    end
  end

  always_comb begin
    if (i_pcs.gbe_mode) begin
      adv_view = adv_q;
    end else if (i_pcs.sgmii_phy_side) begin
      adv_view = (adv_q & pamr_pkg::ADV_PHY_MASK) | pamr_pkg::ADV_SGMII_ONE;
    end else begin
      adv_view = pamr_pkg::ADV_MAC_VALUE;
    end
    if (i_pcs.gbe_mode) begin
      partner_view = i_pcs.partner_word;
    end else begin
      partner_view = (i_pcs.partner_word & pamr_pkg::LP_SGMII_MASK) | pamr_pkg::ADV_SGMII_ONE;
    end
  end

  // Set wins over the read-clear for the page latch; a link drop wins over the read-set for the link latch.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      link_latch_q <= 1'b0;
      page_latch_q <= 1'b0;
    end else begin
      if (!i_pcs.link_up) begin
        link_latch_q <= 1'b0;
      end else if (rd_stb && reg_addr == pamr_pkg::REG_STATUS) begin
        link_latch_q <= 1'b1;
      end
      if (i_pcs.page_received) begin
        page_latch_q <= 1'b1;
      end else if (rd_stb && reg_addr == pamr_pkg::REG_EXPANSION) begin
        page_latch_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_data = 16'h0000;
    unique case (reg_addr)
      pamr_pkg::REG_CONTROL: begin
        rd_data = ctl_q;
        rd_data[pamr_pkg::CTL_SPEED_HI_BIT] = ctl_q[pamr_pkg::CTL_SPEED_HI_BIT] | i_pcs.gbe_mode;
        rd_data[pamr_pkg::CTL_SPEED_LO_BIT] = ctl_q[pamr_pkg::CTL_SPEED_LO_BIT] & !i_pcs.gbe_mode;
      end
      pamr_pkg::REG_STATUS: begin
        rd_data = pamr_pkg::STS_FIXED_ONES;
        rd_data[pamr_pkg::STS_UNIDIR_BIT] = i_pcs.unidir_able;
        rd_data[pamr_pkg::STS_AN_DONE_BIT] = i_pcs.an_complete;
        rd_data[pamr_pkg::STS_LINK_BIT] = link_latch_q;
      end
      pamr_pkg::REG_ADVERTISED: rd_data = adv_view;
      pamr_pkg::REG_PARTNER: rd_data = partner_view;
      pamr_pkg::REG_EXPANSION: rd_data[pamr_pkg::EXP_PAGE_BIT] = page_latch_q;
      pamr_pkg::REG_EXT_STATUS: rd_data = pamr_pkg::EXT_STATUS_VALUE;
      default: rd_data = 16'h0000;
    endcase
  end

  // Rate resolution; the duplex bit is deliberately not used here.
  always_comb begin
    if (i_pcs.gbe_mode) begin
      speed_sel = pamr_pkg::SPEED_1G;
    end else if (!ctl_q[pamr_pkg::CTL_AN_ENABLE_BIT]) begin
      speed_sel = {ctl_q[pamr_pkg::CTL_SPEED_HI_BIT], ctl_q[pamr_pkg::CTL_SPEED_LO_BIT]};
    end else if (i_pcs.sgmii_phy_side) begin
      speed_sel = adv_q[pamr_pkg::ADV_SPEED_LSB +: 2];
    end else begin
      speed_sel = i_pcs.partner_word[pamr_pkg::ADV_SPEED_LSB +: 2];
    end
  end

  always_comb begin
    o_ctl.soft_reset = ctl_q[pamr_pkg::CTL_RESET_BIT];
    o_ctl.loopback = ctl_q[pamr_pkg::CTL_LOOPBACK_BIT];
    o_ctl.an_enable = ctl_q[pamr_pkg::CTL_AN_ENABLE_BIT];
    o_ctl.an_restart = ctl_q[pamr_pkg::CTL_AN_RESTART_BIT];
    o_ctl.power_down = ctl_q[pamr_pkg::CTL_POWER_DOWN_BIT];
    o_ctl.isolate = ctl_q[pamr_pkg::CTL_ISOLATE_BIT];
    o_ctl.unidirectional = ctl_q[pamr_pkg::CTL_UNIDIR_BIT];
    o_ctl.operational_rate = speed_sel;
    o_ctl.advertised_word = adv_view;
  end

  link_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_pcs.link_up |=> !link_latch_q) else $error("link bit not latched low");
  link_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(link_latch_q) == 1'b0 && link_latch_q |-> $past(rd_stb)) else $error("link bit rose unread");
  page_latch_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_pcs.page_received |=> page_latch_q) else $error("page bit not set");
  page_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(page_latch_q) |-> $past(rd_stb) && $past(reg_addr) == pamr_pkg::REG_EXPANSION)
    else $error("page bit cleared without read");
  gbe_rate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_pcs.gbe_mode |-> o_ctl.operational_rate == pamr_pkg::SPEED_1G) else $error("gbe rate wrong");
  an_rate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_pcs.gbe_mode && i_pcs.sgmii_phy_side && o_ctl.an_enable |->
    o_ctl.operational_rate == adv_q[11:10]) else $error("rate not from advertised");
  stuck_bits_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ctl_q[7] == 1'b0 && ctl_q[4:0] == 5'h00) else $error("stuck control bit set");
  status_fixed_a: assert property (@(posedge i_clk) disable iff (i_rst)
    reg_addr == pamr_pkg::REG_STATUS |-> rd_data[8] && rd_data[3] && rd_data[15:9] == 7'h00)
    else $error("status constant wrong");
  mac_adv_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_pcs.gbe_mode && !i_pcs.sgmii_phy_side |-> adv_view == 16'h4001) else $error("mac adv wrong");
  self_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ctl_q[15] && !wr_stb |=> !ctl_q[15]) else $error("reset bit stuck");
  ctl_speed_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_pcs.gbe_mode && reg_addr == pamr_pkg::REG_CONTROL |-> rd_data[6] && !rd_data[13])
    else $error("speed bits not forced");
  gbe_adv_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_pcs.gbe_mode && wr_stb && reg_addr == pamr_pkg::REG_ADVERTISED && !ctl_q[15] |=>
    adv_q == $past(wr_data)) else $error("adv write lost");
  partner_sgmii_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_pcs.gbe_mode |-> partner_view[0] && partner_view[13] == 1'b0 &&
    partner_view[9:1] == 9'h000) else $error("partner fields wrong");
  status_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    reg_addr == pamr_pkg::REG_STATUS |-> rd_data[6] == 1'b0 && rd_data[4] == 1'b0 &&
    rd_data[1:0] == 2'h0) else $error("status zero bits wrong");
  read_drive_a: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_stb |=> o_mdio_oe) else $error("read data not driven");
  duplex_free_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $changed(ctl_q[8]) && $stable(ctl_q[13:12]) && $stable(ctl_q[6]) && $stable(adv_q) &&
    $stable(i_pcs) |-> $stable(o_ctl.operational_rate)) else $error("duplex steers rate");

  write_cov_c: cover property (@(posedge i_clk) wr_stb);
  read_cov_c: cover property (@(posedge i_clk) rd_stb && reg_addr == pamr_pkg::REG_STATUS);
  drop_cov_c: cover property (@(posedge i_clk) $fell(link_latch_q));
  gbe_write_c: cover property (@(posedge i_clk) i_pcs.gbe_mode && wr_stb);
  soft_reset_c: cover property (@(posedge i_clk) ctl_q[15]);

endmodule : pamr_regs

// ### verif/pamr_mdio_host.sv
// Management host: drives MDC and MDIO, samples read data just before MDC rises.
module pamr_mdio_host (
  // Clock
  input wire logic i_clk,
  // Management pins
  input wire logic i_mdio,
  output logic o_mdc,
  output logic o_mdio,
  output logic o_mdio_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_mdc = 1'h0;
    o_mdio = 1'h1;
    o_mdio_oe = 1'h0;
  end

  // One MDC period of ten clocks; data changes while MDC is low.
  task automatic put_bit(input logic b, input logic en, output logic smp);
    @(posedge i_clk);
    #1;
    o_mdc = 1'h0;
    o_mdio_oe = en;
    o_mdio = b;
    repeat (5) @(posedge i_clk);
    #1 smp = i_mdio;
    o_mdc = 1'h1;
    repeat (4) @(posedge i_clk);
  endtask : put_bit

  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] adr,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [45:0] hdr;
    logic s;
    logic wr;
    hdr = {32'hFFFF_FFFF, pamr_pkg::MF_START, op, phy, adr};
    wr = (op == pamr_pkg::MF_OP_WRITE);
    for (int i = 45; i >= 0; i--) begin
      put_bit(hdr[i], 1'h1, s);
    end
    put_bit(1'h1, wr, s);
    put_bit(1'h0, wr, s);
    for (int i = 15; i >= 0; i--) begin
      put_bit(wd[i], wr, s);
      rd[i] = s;
    end
    @(posedge i_clk);
    #1;
    o_mdc = 1'h0;
    o_mdio_oe = 1'h0;
    repeat (10) @(posedge i_clk);
    #1;
  endtask : frame
endmodule : pamr_mdio_host

// ### verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [4:0] PORT = 5'h05;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic mdc;
  logic host_mdio;
  logic host_oe;
  logic dev_mdio;
  logic dev_oe;
  logic [15:0] junk;
  wire mdio_line;
  pamr_pkg::pamr_pcs_status_t pcs;
  pamr_pkg::pamr_pcs_control_t ctl;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;

  // The data line has a pull-up, so a released line reads one.
  assign mdio_line = dev_oe ? dev_mdio : (host_oe ? host_mdio : 1'h1);

  always #20 i_clk = ~i_clk;

  pamr_regs pamr_regs_inst (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_mdc(mdc),
    .i_mdio(mdio_line),
    .o_mdio(dev_mdio),
    .o_mdio_oe(dev_oe),
    .i_phy_addr(PORT),
    .i_pcs(pcs),
    .o_ctl(ctl)
  );

  pamr_mdio_host pamr_mdio_host_inst (
    .i_clk(i_clk),
    .i_mdio(mdio_line),
    .o_mdc(mdc),
    .o_mdio(host_mdio),
    .o_mdio_oe(host_oe)
  );

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [4:0] adr, input logic [15:0] d);
    pamr_mdio_host_inst.frame(pamr_pkg::MF_OP_WRITE, PORT, adr, d, junk);
  endtask : wr

  task automatic rd(input logic [4:0] adr, input logic [15:0] exp);
    logic [15:0] v;
    pamr_mdio_host_inst.frame(pamr_pkg::MF_OP_READ, PORT, adr, 16'h0000, v);
    check($sformatf("reg %h", adr), v, exp);
  endtask : rd

  task automatic rate(input logic [1:0] exp);
    check("rate", {14'h0000, ctl.operational_rate}, {14'h0000, exp});
  endtask : rate

  task automatic pulse_low_link();
    pcs.link_up = 1'h0;
    repeat (3) @(posedge i_clk);
    #1 pcs.link_up = 1'h1;
  endtask : pulse_low_link

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    pcs = '0;
    pcs.sgmii_phy_side = 1'h1;
    pcs.link_up = 1'h1;
    pcs.an_complete = 1'h1;
    repeat (6) @(posedge i_clk);
    #1 i_rst = 1'h0;
    rd(pamr_pkg::REG_CONTROL, 16'h1140);
    pamr_mdio_host_inst.frame(pamr_pkg::MF_OP_READ, PORT, pamr_pkg::REG_STATUS, 16'h0000, junk);
    rd(pamr_pkg::REG_STATUS, 16'h012C);
    pcs.unidir_able = 1'h1;
    pcs.an_complete = 1'h0;
    pulse_low_link();
    rd(pamr_pkg::REG_STATUS, 16'h0188);
    rd(pamr_pkg::REG_STATUS, 16'h018C);
    wr(pamr_pkg::REG_CONTROL, 16'h019F);
    rd(pamr_pkg::REG_CONTROL, 16'h0100);
    rate(pamr_pkg::SPEED_10M);
    wr(pamr_pkg::REG_CONTROL, 16'h2000);
    rd(pamr_pkg::REG_CONTROL, 16'h2000);
    rate(pamr_pkg::SPEED_100M);
    wr(pamr_pkg::REG_ADVERTISED, 16'hFFFF);
    rd(pamr_pkg::REG_ADVERTISED, 16'hDC01);
    check("adv out", ctl.advertised_word, 16'hDC01);
    wr(pamr_pkg::REG_ADVERTISED, 16'h0401);
    wr(pamr_pkg::REG_CONTROL, 16'h1000);
    rate(pamr_pkg::SPEED_100M);
    pcs.sgmii_phy_side = 1'h0;
    pcs.partner_word = 16'hFFFF;
    rd(pamr_pkg::REG_ADVERTISED, 16'h4001);
    rd(pamr_pkg::REG_PARTNER, 16'hDC01);
    pcs.partner_word = 16'h0800;
    #1 rate(pamr_pkg::SPEED_1G);
    pamr_mdio_host_inst.frame(pamr_pkg::MF_OP_WRITE, 5'h03, pamr_pkg::REG_CONTROL, 16'h0000, junk);
    rd(pamr_pkg::REG_CONTROL, 16'h1000);
    pcs.page_received = 1'h1;
    @(posedge i_clk);
    #1 pcs.page_received = 1'h0;
    rd(pamr_pkg::REG_EXPANSION, 16'h0002);
    rd(pamr_pkg::REG_EXPANSION, 16'h0000);
    pcs.gbe_mode = 1'h1;
    wr(pamr_pkg::REG_ADVERTISED, 16'hFFFF);
    rd(pamr_pkg::REG_ADVERTISED, 16'hFFFF);
    rd(pamr_pkg::REG_PARTNER, 16'h0800);
    wr(pamr_pkg::REG_CONTROL, 16'h0000);
    rd(pamr_pkg::REG_CONTROL, 16'h0040);
    rate(pamr_pkg::SPEED_1G);
    wr(pamr_pkg::REG_CONTROL, 16'h8000);
    rd(pamr_pkg::REG_CONTROL, 16'h0040);
    rd(pamr_pkg::REG_ADVERTISED, 16'h0020);
    wr(pamr_pkg::REG_CONTROL, 16'h4EBF);
    rd(pamr_pkg::REG_CONTROL, 16'h4C60);
    check("ctl flags", {9'h000, ctl.soft_reset, ctl.loopback, ctl.an_enable, ctl.an_restart,
          ctl.power_down, ctl.isolate, ctl.unidirectional}, 16'h0027);
    print_verdict();
  end
endmodule : tb_top
